// ---- common/enhanced_capture_unit_pkg.sv ----
package enhanced_capture_unit_pkg;
  // Register map of the plain register port (byte offsets)
  localparam logic [3:0] ADDR_CONTROL     = 4'h0;
  localparam logic [3:0] ADDR_CAPT_LOW    = 4'h1;
  localparam logic [3:0] ADDR_CAPT_HIGH   = 4'h2;
  localparam logic [3:0] ADDR_FLAGS       = 4'h3;
  localparam logic [3:0] ADDR_ENABLES     = 4'h4;
  localparam logic [3:0] ADDR_PORT_DATA   = 4'h5;
  localparam logic [3:0] ADDR_PORT_DIR    = 4'h6;

  localparam logic [7:0] CONTROL_RESET    = 8'h00;
  localparam logic [7:0] PORT_DIR_RESET   = 8'h0F;
  localparam int         FLAG_BIT         = 2;

  // Control register fields
  localparam int MODE_LSB   = 0;
  localparam int DUTY_LSB   = 4;
  localparam int BRIDGE_LSB = 6;

  typedef enum logic [3:0] {
    MODE_OFF        = 4'h0,
    MODE_CMP_TOGGLE = 4'h2,
    MODE_CAP_FALL   = 4'h4,
    MODE_CAP_RISE   = 4'h5,
    MODE_CAP_RISE4  = 4'h6,
    MODE_CAP_RISE16 = 4'h7,
    MODE_CMP_SET    = 4'h8,
    MODE_CMP_CLEAR  = 4'h9,
    MODE_CMP_SWIRQ  = 4'hA,
    MODE_CMP_SPECL  = 4'hB,
    MODE_PWM_HHHH   = 4'hC,
    MODE_PWM_HLHL   = 4'hD,
    MODE_PWM_LHLH   = 4'hE,
    MODE_PWM_LLLL   = 4'hF
  } mode_t;

  typedef enum logic [1:0] {
    BRIDGE_SINGLE  = 2'h0,
    BRIDGE_FWD     = 2'h1,
    BRIDGE_HALF    = 2'h2,
    BRIDGE_REV     = 2'h3
  } bridge_t;

  localparam logic [3:0] PRESCALE_4_LAST  = 4'h3;
  localparam logic [3:0] PRESCALE_16_LAST = 4'hF;
  localparam logic [1:0] PWM_MODE_TOP     = 2'h3;
  localparam logic [3:0] DEAD_BAND_CYCLES = 4'h2;
endpackage : enhanced_capture_unit_pkg

// ---- hdl/capture_unit.sv ----
// Functional notes
// - Mode 0000 turns the unit off and resets its internal state.
// - Capture on falling, rising, every 4th or 16th rising edge.
// - Compare match toggles, sets or clears output and sets flag.
// - Mode 1010 match sets only the flag, pin untouched.
// - Mode 1011 match sets flag and fires timer-reset trigger.
// - PWM codes 1100, 1101, 1110, 1111 set output polarities.
// - Outside PWM the bridge field is ignored; outputs b-d are port pins.
// - Bridge 10 is half bridge: a, b modulated with dead band.
// - Bridge 11 reverse: b modulated, c active, a and d inactive.
// - Bridge forward: d modulated, a active, b and c inactive.
// - Single output modulates only a; b, c, d are port pins.
// - Duty is capture low byte (high eight) plus duty low bits.
// - A capture event copies the 16-bit timer into the capture pair unless software writes either half that cycle.
// - Capture sets the flag; only software clears it.
// - A newer capture overwrites an unread one.
// - Edge detector watches the pin level even when driven as output.
// - Prescaler counter clears on reset, when off, or outside capture.
// - Direct prescale change keeps the counter; clear control first.
// - Capture and compare use the 16-bit timer, PWM the 8-bit timer.
// - Clearing control forces the compare output latch low.
// - Special trigger fires at once; timer resets on its next tick.
`timescale 1ns/100ps
`default_nettype none
module capture_unit (
  // Clock and reset
  input  wire logic        MCLK,
  input  wire logic        RST_N,
  // Register port
  input  wire logic [3:0]  ADDR,
  input  wire logic [7:0]  WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [7:0]  RDATA,
  // Timers
  input  wire logic [15:0] TIMER16,
  input  wire logic        TIMER16_TICK,
  input  wire logic [7:0]  TIMER8,
  input  wire logic [1:0]  TIMER8_PRESCALE,
  input  wire logic        TIMER8_PERIOD,
  output logic             TIMER16_RESET,
  output logic             SPECIAL_TRIGGER,
  // Bridge pins a..d
  input  wire logic [3:0]  PIN_IN,
  output logic      [3:0]  PIN_OUT,
  output logic      [3:0]  PIN_OE,
  // Flag level
  output logic             UNIT_IRQ
);

  logic [7:0]  capture_unit_control;
  logic [7:0]  capture_value_low;
  logic [7:0]  capture_value_high;
  logic        unit_irq_flag;
  logic        unit_irq_enable;
  logic [3:0]  port_data;
  logic [3:0]  port_dir;
  logic [3:0]  pin_meta;
  logic [3:0]  pin_sync;
  logic        pin_prev;
  logic [3:0]  prescale_cnt;
  logic        compare_latch;
  logic        match_prev;
  logic        reset_pending;
  logic [9:0]  duty_shadow;
  logic [9:0]  pwm_count;
  logic        pwm_level;
  logic [3:0]  dead_cnt;
  logic        pwm_a_q;
  logic        pwm_b_q;

  enhanced_capture_unit_pkg::mode_t   unit_mode_select;
  enhanced_capture_unit_pkg::bridge_t bridge_output_config;
  logic [1:0]        duty_low_bits;
  logic              is_capture;
  logic              is_compare;
  logic              is_pwm;
  logic              rise_edge;
  logic              fall_edge;
  logic              edge_hit;
  logic              capture_event;
  logic              match;
  logic              match_rise;
  logic              flag_set;
  logic              wr_flags;
  logic              next_flag;
  logic [3:0]        next_out;
  logic [3:0]        next_oe;
  logic [3:0]        port_oe;
  logic              pol_ac_low;
  logic              pol_bd_low;
  logic [7:0]        next_rdata;

  assign unit_mode_select     = enhanced_capture_unit_pkg::mode_t'(capture_unit_control[enhanced_capture_unit_pkg::MODE_LSB +: 4]);
  assign bridge_output_config =
    enhanced_capture_unit_pkg::bridge_t'(capture_unit_control[enhanced_capture_unit_pkg::BRIDGE_LSB +: 2]);
  assign duty_low_bits        = capture_unit_control[enhanced_capture_unit_pkg::DUTY_LSB +: 2];
  // Reserved codes 0001 and 0011 behave as off: no capture, compare or PWM
  // Decoding them as off keeps a stray write from driving the pins
  assign is_capture = (unit_mode_select[3:2] == 2'h1);
  assign is_pwm     = (unit_mode_select[3:2] == enhanced_capture_unit_pkg::PWM_MODE_TOP);
  assign is_compare = !is_capture && !is_pwm && (unit_mode_select != enhanced_capture_unit_pkg::MODE_OFF)
                      && (unit_mode_select != 4'h1) && (unit_mode_select != 4'h3);
  assign port_oe    = ~port_dir;

  // Pin synchroniser
  // Pads are asynchronous; two flops guard against metastability
  // Edge flop idles low like the pad, so no false edge follows reset
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      pin_meta <= 4'h0;
      pin_sync <= 4'h0;
      pin_prev <= 1'b0;
    end else begin
      pin_meta <= PIN_IN;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync[0];
    end
  end

  assign rise_edge = pin_sync[0] && !pin_prev;
  assign fall_edge = !pin_sync[0] && pin_prev;
  assign edge_hit  = (unit_mode_select == enhanced_capture_unit_pkg::MODE_CAP_FALL) ? fall_edge : rise_edge;
  always_comb begin
    capture_event = 1'b0;
    if (is_capture && edge_hit) begin
      case (unit_mode_select)
        enhanced_capture_unit_pkg::MODE_CAP_RISE4:  capture_event = (prescale_cnt[1:0] == enhanced_capture_unit_pkg::PRESCALE_4_LAST[1:0]);
        enhanced_capture_unit_pkg::MODE_CAP_RISE16: capture_event = (prescale_cnt == enhanced_capture_unit_pkg::PRESCALE_16_LAST);
        default:                   capture_event = 1'b1;
      endcase
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      prescale_cnt <= 4'h0;
    end else if (!is_capture) begin
      prescale_cnt <= 4'h0;
    end else if (edge_hit) begin
      prescale_cnt <= prescale_cnt + 4'h1;
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      capture_value_low  <= 8'h00;
      capture_value_high <= 8'h00;
    end else if (WR && ADDR == enhanced_capture_unit_pkg::ADDR_CAPT_LOW) begin
      capture_value_low  <= WDATA;
    end else if (WR && ADDR == enhanced_capture_unit_pkg::ADDR_CAPT_HIGH) begin
      capture_value_high <= WDATA;
    end else if (capture_event) begin
      capture_value_low  <= TIMER16[7:0];
      capture_value_high <= TIMER16[15:8];
    end
  end

  // Compare match against the 16-bit timer
  // Only the first matching cycle acts, so a stalled timer fires once
  assign match      = is_compare && (TIMER16 == {capture_value_high, capture_value_low});
  assign match_rise = match && !match_prev;

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      match_prev <= 1'b0;
    end else begin
      match_prev <= match;
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      compare_latch <= 1'b0;
    end else if (unit_mode_select == enhanced_capture_unit_pkg::MODE_OFF) begin
      compare_latch <= 1'b0;
    end else if (match_rise) begin
      case (unit_mode_select)
        enhanced_capture_unit_pkg::MODE_CMP_TOGGLE: compare_latch <= !compare_latch;
        enhanced_capture_unit_pkg::MODE_CMP_SET:    compare_latch <= 1'b1;
        enhanced_capture_unit_pkg::MODE_CMP_CLEAR:  compare_latch <= 1'b0;
        default:                   compare_latch <= compare_latch;
      endcase
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      SPECIAL_TRIGGER <= 1'b0;
      reset_pending   <= 1'b0;
      TIMER16_RESET   <= 1'b0;
    end else begin
      SPECIAL_TRIGGER <= match_rise && unit_mode_select == enhanced_capture_unit_pkg::MODE_CMP_SPECL;
      TIMER16_RESET   <= reset_pending && match && TIMER16_TICK;
      if (match_rise && unit_mode_select == enhanced_capture_unit_pkg::MODE_CMP_SPECL) begin
        reset_pending <= 1'b1;
      end else if (!match || TIMER16_TICK) begin
        // Moving the compare value away cancels the pending reset
        reset_pending <= 1'b0;
      end
    end
  end

  assign flag_set = capture_event || match_rise;
  assign wr_flags = WR && ADDR == enhanced_capture_unit_pkg::ADDR_FLAGS;
  assign next_flag = flag_set ? 1'b1 : (wr_flags ? WDATA[enhanced_capture_unit_pkg::FLAG_BIT] : unit_irq_flag);

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      unit_irq_flag <= 1'b0;
      UNIT_IRQ      <= 1'b0;
    end else begin
      unit_irq_flag <= next_flag;
      UNIT_IRQ      <= next_flag && unit_irq_enable;
    end
  end

  // Software registers
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      capture_unit_control <= enhanced_capture_unit_pkg::CONTROL_RESET;
      unit_irq_enable      <= 1'b0;
      port_data            <= 4'h0;
      port_dir             <= enhanced_capture_unit_pkg::PORT_DIR_RESET[3:0];
    end else if (WR) begin
      case (ADDR)
        enhanced_capture_unit_pkg::ADDR_CONTROL:   capture_unit_control <= WDATA;
        enhanced_capture_unit_pkg::ADDR_ENABLES:   unit_irq_enable      <= WDATA[enhanced_capture_unit_pkg::FLAG_BIT];
        enhanced_capture_unit_pkg::ADDR_PORT_DATA: port_data            <= WDATA[3:0];
        enhanced_capture_unit_pkg::ADDR_PORT_DIR:  port_dir             <= WDATA[3:0];
        default: ;
      endcase
    end
  end

  // Read data are zero outside the answer cycle
  // Port data read back the synced pads, not the write latch
  always_comb begin
    case (ADDR)
      enhanced_capture_unit_pkg::ADDR_CONTROL:   next_rdata = capture_unit_control;
      enhanced_capture_unit_pkg::ADDR_CAPT_LOW:  next_rdata = capture_value_low;
      enhanced_capture_unit_pkg::ADDR_CAPT_HIGH: next_rdata = capture_value_high;
      enhanced_capture_unit_pkg::ADDR_FLAGS:     next_rdata = {5'h00, unit_irq_flag, 2'h0};
      enhanced_capture_unit_pkg::ADDR_ENABLES:   next_rdata = {5'h00, unit_irq_enable, 2'h0};
      enhanced_capture_unit_pkg::ADDR_PORT_DATA: next_rdata = {4'h0, pin_sync};
      enhanced_capture_unit_pkg::ADDR_PORT_DIR:  next_rdata = {4'h0, port_dir};
      default:                  next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      RDATA <= 8'h00;
    end else begin
      RDATA <= RD ? next_rdata : 8'h00;
    end
  end

  // PWM on 8-bit timer
  // Duty is taken at each period end so a mid-period write cannot glitch
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      duty_shadow <= 10'h000;
      pwm_level   <= 1'b0;
    end else if (!is_pwm) begin
      duty_shadow <= 10'h000;
      pwm_level   <= 1'b0;
    end else if (TIMER8_PERIOD) begin
      duty_shadow <= {capture_value_low, duty_low_bits};
      pwm_level   <= ({capture_value_low, duty_low_bits} != 10'h000);
    end else if (pwm_count >= duty_shadow) begin
      pwm_level   <= 1'b0;
    end
  end
  assign pwm_count = {TIMER8, TIMER8_PRESCALE};

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      dead_cnt <= 4'h0;
      pwm_a_q  <= 1'b0;
      pwm_b_q  <= 1'b0;
    end else if (!is_pwm) begin
      dead_cnt <= 4'h0;
      pwm_a_q  <= 1'b0;
      pwm_b_q  <= 1'b0;
    end else if (pwm_level != pwm_a_q && pwm_level == pwm_b_q) begin
      // Break before make: both sides idle through the dead band
      pwm_a_q  <= 1'b0;
      pwm_b_q  <= 1'b0;
      dead_cnt <= enhanced_capture_unit_pkg::DEAD_BAND_CYCLES;
    end else if (dead_cnt != 4'h0) begin
      dead_cnt <= dead_cnt - 4'h1;
    end else begin
      pwm_a_q  <= pwm_level;
      pwm_b_q  <= !pwm_level;
    end
  end

  assign pol_ac_low = (unit_mode_select == enhanced_capture_unit_pkg::MODE_PWM_LHLH)
                      || (unit_mode_select == enhanced_capture_unit_pkg::MODE_PWM_LLLL);
  assign pol_bd_low = (unit_mode_select == enhanced_capture_unit_pkg::MODE_PWM_HLHL)
                      || (unit_mode_select == enhanced_capture_unit_pkg::MODE_PWM_LLLL);

  always_comb begin
    next_out = port_data;
    next_oe  = port_oe;
    if (is_pwm) begin
      case (bridge_output_config)
        enhanced_capture_unit_pkg::BRIDGE_SINGLE: begin
          next_out[0] = pwm_level ^ pol_ac_low;
          next_oe[0]  = 1'b1;
        end
        enhanced_capture_unit_pkg::BRIDGE_FWD: begin
          next_out = {pwm_level ^ pol_bd_low, pol_ac_low, pol_bd_low, !pol_ac_low};
          next_oe  = 4'hF;
        end
        enhanced_capture_unit_pkg::BRIDGE_HALF: begin
          next_out[1:0] = {pwm_b_q ^ pol_bd_low, pwm_a_q ^ pol_ac_low};
          next_oe[1:0]  = 2'h3;
        end
        enhanced_capture_unit_pkg::BRIDGE_REV: begin
          next_out = {pol_bd_low, !pol_ac_low, pwm_level ^ pol_bd_low, pol_ac_low};
          next_oe  = 4'hF;
        end
        default: ;
      endcase
    end else if (unit_mode_select == enhanced_capture_unit_pkg::MODE_CMP_TOGGLE
                 || unit_mode_select == enhanced_capture_unit_pkg::MODE_CMP_SET
                 || unit_mode_select == enhanced_capture_unit_pkg::MODE_CMP_CLEAR) begin
      next_out[0] = compare_latch;
    end
  end

  // off restores pins
  // Registered pins: one cycle of latency traded for glitch-free pads
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      PIN_OUT <= 4'h0;
      PIN_OE  <= 4'h0;
    end else begin
      PIN_OUT <= next_out;
      PIN_OE  <= next_oe;
    end
  end

endmodule : capture_unit
`default_nettype wire

// ---- dv/event_source.sv ----
`timescale 1ns/100ps
`default_nettype none
module event_source (
  // Clock
  input  wire logic       mclk,
  // Pad levels a..d
  output logic      [3:0] ext
);
  initial ext = 4'h0;
  // input pin only
  // Pads b..d have no source, so they toggle instead of holding a stale level
  always @(posedge mclk) ext[3:1] <= ~ext[3:1];
  task automatic drive(input logic v, input int n);
    @(posedge mclk);
    ext[0] <= v;
    repeat (n) @(posedge mclk);
  endtask : drive
  task automatic pulse(input int n);
    drive(1'b1, n);
    drive(1'b0, n);
  endtask : pulse
endmodule : event_source
`default_nettype wire

// ---- dv/capture_unit_checker.sv ----
`timescale 1ns/100ps
`default_nettype none
module capture_unit_checker (
  // Clock and reset
  input wire logic       MCLK,
  input wire logic       RST_N,
  // Register port
  input wire logic [3:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic       WR,
  input wire logic       RD,
  input wire logic [7:0] RDATA,
  // Timer and pins
  input wire logic       TIMER16_TICK,
  input wire logic       TIMER16_RESET,
  input wire logic       SPECIAL_TRIGGER,
  input wire logic [3:0] PIN_IN,
  input wire logic [3:0] PIN_OUT,
  input wire logic [3:0] PIN_OE,
  input wire logic       UNIT_IRQ
);
  logic [7:0]      ctrl;
  logic [3:0]      dir;
  logic            en;
  wire logic [3:0] mode = ctrl[3:0];
  wire logic       sw  = WR && (ADDR == 4'h0 || ADDR == 4'h3 || ADDR == 4'h4);
  // Mirror of the software-written settings
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl <= enhanced_capture_unit_pkg::CONTROL_RESET;
      dir  <= enhanced_capture_unit_pkg::PORT_DIR_RESET[3:0];
      en   <= 1'b0;
    end else if (WR) begin
      if (ADDR == enhanced_capture_unit_pkg::ADDR_CONTROL) ctrl <= WDATA;
      if (ADDR == enhanced_capture_unit_pkg::ADDR_PORT_DIR) dir <= WDATA[3:0];
      if (ADDR == enhanced_capture_unit_pkg::ADDR_ENABLES) en <= WDATA[enhanced_capture_unit_pkg::FLAG_BIT];
    end
  end
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  sequence s_cap_edge;
    en && ((mode == 4'h4 && $fell(PIN_IN[0])) || (mode == 4'h5 && $rose(PIN_IN[0])));
  endsequence
  sequence s_irq_soon;
    ##[1:6] UNIT_IRQ;
  endsequence
  property p_cap_irq;
    s_cap_edge |-> s_irq_soon;
  endproperty
  property p_trig_mode;
    SPECIAL_TRIGGER |-> $past(mode) == 4'hB;
  endproperty
  property p_trig_once;
    SPECIAL_TRIGGER |=> !SPECIAL_TRIGGER;
  endproperty
  property p_tres;
    TIMER16_RESET |-> $past(TIMER16_TICK) && $past(mode) == 4'hB;
  endproperty
  property p_port;
    (mode[3:2] != 2'b11 || ctrl[7:6] == 2'b00) && $stable(ctrl) && $past(ctrl, 2) == ctrl
      |-> PIN_OE[3:1] == ~$past(dir[3:1]);
  endproperty
  property p_rev;
    mode[3:2] == 2'b11 && ctrl[7:6] == 2'b11 && $stable(ctrl) && $past(ctrl, 2) == ctrl
      |-> PIN_OUT[0] == mode[1] && PIN_OUT[2] == !mode[1] && PIN_OUT[3] == mode[0];
  endproperty
  property p_fwd;
    mode[3:2] == 2'b11 && ctrl[7:6] == 2'b01 && $stable(ctrl) && $past(ctrl, 2) == ctrl
      |-> PIN_OUT[0] == !mode[1] && PIN_OUT[1] == mode[0] && PIN_OUT[2] == mode[1];
  endproperty
  property p_flag_hold;
    $fell(UNIT_IRQ) |-> $past(sw) || $past(sw, 2);
  endproperty
  property p_ctrl_rd;
    RD && ADDR == enhanced_capture_unit_pkg::ADDR_CONTROL |=> RDATA == $past(ctrl);
  endproperty
  a_cap_irq: assert property (p_cap_irq)
    else $error("capture edge raised no request");
  a_trig_mode: assert property (p_trig_mode)
    else $error("trigger outside special event mode");
  a_trig_once: assert property (p_trig_once)
    else $error("trigger longer than one cycle");
  a_tres: assert property (p_tres)
    else $error("timer reset without tick");
  a_port: assert property (p_port)
    else $error("pins b to d not port pins");
  a_rev: assert property (p_rev)
    else $error("reverse bridge levels wrong");
  a_fwd: assert property (p_fwd)
    else $error("forward bridge levels wrong");
  a_flag_hold: assert property (p_flag_hold)
    else $error("request dropped without software");
  a_ctrl_rd: assert property (p_ctrl_rd)
    else $error("control readback wrong");
endmodule : capture_unit_checker
bind capture_unit capture_unit_checker u_chk (
  .MCLK(MCLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
  .RDATA(RDATA), .TIMER16_TICK(TIMER16_TICK), .TIMER16_RESET(TIMER16_RESET),
  .SPECIAL_TRIGGER(SPECIAL_TRIGGER), .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT),
  .PIN_OE(PIN_OE), .UNIT_IRQ(UNIT_IRQ)
);
`default_nettype wire

// ---- dv/enhanced_capture_mode_control_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module enhanced_capture_mode_control_tb;
  logic            mclk = 1'b0;
  logic            rst_n = 1'b0;
  logic [3:0]      addr = 4'h0;
  logic [7:0]      wdata = 8'h00;
  logic            wr = 1'b0;
  logic            rd = 1'b0;
  logic [15:0]     t16 = 16'h0000;
  logic            tick = 1'b0;
  logic [7:0]      t8 = 8'h00;
  logic [7:0]      rdata, d;
  logic [3:0]      pin_out, pin_oe, ext;
  logic            t16_rst, trig, irq, p;
  wire logic [3:0] pad = (pin_oe & pin_out) | (~pin_oe & ext);
  logic [31:0]     seed = 32'd47;
  logic [15:0]     v;
  logic [3:0]      codes [5] = '{4'h2, 4'h9, 4'h8, 4'hA, 4'hB};
  int              fail_count = 0;
  int              checked = 0;
  int              cyc = 0;
  int              trig_n = 0;
  int              res_n = 0;
  int              t0, r0;
  capture_unit dut (
    .MCLK(mclk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .TIMER16(t16), .TIMER16_TICK(tick), .TIMER8(t8),
    .TIMER8_PRESCALE(t8[1:0]), .TIMER8_PERIOD(t8 == 8'hFF), .TIMER16_RESET(t16_rst),
    .SPECIAL_TRIGGER(trig), .PIN_IN(pad), .PIN_OUT(pin_out), .PIN_OE(pin_oe),
    .UNIT_IRQ(irq)
  );
  event_source ev (.mclk(mclk), .ext(ext));
  initial forever #50 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    t8 <= t8 + 8'h01;
    trig_n += int'(trig);
    res_n += int'(t16_rst);
    if (cyc == 20000) begin
      fail_count++;
      end_sim();
    end
  end
  function automatic logic [15:0] xorshift();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[15:0];
  endfunction : xorshift
  // Latch after a match; other codes leave it alone
  function automatic logic cmp_pin(input logic [3:0] m, input logic q);
    case (m)
      4'h2: return ~q;
      4'h8: return 1'b1;
      4'h9: return 1'b0;
      default: return q;
    endcase
  endfunction : cmp_pin
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] dt);
    @(posedge mclk);
    addr <= a;
    wdata <= dt;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] dt);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    // Read data stand until the next rising edge; take them there
    @(posedge mclk);
    dt = rdata;
  endtask : rd_reg
  task automatic flag_chk(input logic e);
    rd_reg(enhanced_capture_unit_pkg::ADDR_FLAGS, d);
    chk(16'(d[enhanced_capture_unit_pkg::FLAG_BIT]), 16'(e));
  endtask : flag_chk
  task automatic cap_chk(input logic [15:0] e);
    logic [7:0] lo;
    rd_reg(enhanced_capture_unit_pkg::ADDR_CAPT_LOW, lo);
    rd_reg(enhanced_capture_unit_pkg::ADDR_CAPT_HIGH, d);
    chk({d, lo}, e);
  endtask : cap_chk
  task automatic hit(input logic [15:0] val);
    @(posedge mclk);
    t16 <= val;
    repeat (2) @(posedge mclk);
    tick <= 1'b1;
    @(posedge mclk);
    tick <= 1'b0;
    repeat (3) @(posedge mclk);
    t16 <= val + 16'h0001;
    repeat (3) @(posedge mclk);
  endtask : hit
  task automatic end_sim();
    $display("checked %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim
  initial begin
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    rd_reg(enhanced_capture_unit_pkg::ADDR_CONTROL, d);
    chk(16'(d), 16'h0000);
    wr_reg(4'h7, 8'hA5);
    rd_reg(4'h7, d);
    chk(16'(d), 16'h0000);
    repeat (8) begin
      v = xorshift();
      wr_reg(enhanced_capture_unit_pkg::ADDR_CONTROL, v[7:0]);
      rd_reg(enhanced_capture_unit_pkg::ADDR_CONTROL, d);
      chk(16'(d), 16'(v[7:0]));
    end
    $display("test registers done");
    wr_reg(enhanced_capture_unit_pkg::ADDR_ENABLES, 8'h01 << enhanced_capture_unit_pkg::FLAG_BIT);
    for (int m = 4; m < 6; m++) begin
      wr_reg(enhanced_capture_unit_pkg::ADDR_CONTROL, 8'(m));
      wr_reg(enhanced_capture_unit_pkg::ADDR_FLAGS, 8'h00);
      v = xorshift();
      @(posedge mclk);
      t16 <= v;
      ev.drive(1'b1, 5);
      t16 <= ~v;
      ev.drive(1'b0, 5);
      cap_chk(m == 4 ? ~v : v);
      flag_chk(1'b1);
      chk(16'(irq), 16'h0001);
    end
    t16 <= v + 16'h0100;
    ev.pulse(4);
    t16 <= v + 16'h0200;
    ev.pulse(4);
    cap_chk(v + 16'h0200);
    $display("test edges done");
    for (int m = 6; m < 8; m++) begin
      wr_reg(enhanced_capture_unit_pkg::ADDR_CONTROL, 8'(m));
      repeat (2) ev.pulse(2);
      wr_reg(enhanced_capture_unit_pkg::ADDR_CONTROL, 8'h00);
      wr_reg(enhanced_capture_unit_pkg::ADDR_CONTROL, 8'(m));
      wr_reg(enhanced_capture_unit_pkg::ADDR_FLAGS, 8'h00);
      repeat ((m == 6 ? 4 : 16) - 1) ev.pulse(2);
      flag_chk(1'b0);
      v = xorshift();
      t16 <= v;
      ev.pulse(3);
      flag_chk(1'b1);
      cap_chk(v);
    end
    $display("test prescale done");
    wr_reg(enhanced_capture_unit_pkg::ADDR_CONTROL, 8'h05);
    wr_reg(enhanced_capture_unit_pkg::ADDR_PORT_DATA, 8'h00);
    wr_reg(enhanced_capture_unit_pkg::ADDR_PORT_DIR, 8'h0E);
    v = xorshift();
    t16 <= v;
    wr_reg(enhanced_capture_unit_pkg::ADDR_PORT_DATA, 8'h01);
    repeat (6) @(posedge mclk);
    cap_chk(v);
    wr_reg(enhanced_capture_unit_pkg::ADDR_PORT_DATA, 8'h00);
    $display("test port capture done");
    wr_reg(enhanced_capture_unit_pkg::ADDR_CONTROL, 8'h00);
    t16 <= v + 16'h0001;
    wr_reg(enhanced_capture_unit_pkg::ADDR_CAPT_LOW, v[7:0]);
    wr_reg(enhanced_capture_unit_pkg::ADDR_CAPT_HIGH, v[15:8]);
    p = 1'b0;
    foreach (codes[i]) begin
      wr_reg(enhanced_capture_unit_pkg::ADDR_CONTROL, {4'h0, codes[i]});
      wr_reg(enhanced_capture_unit_pkg::ADDR_FLAGS, 8'h00);
      t0 = trig_n;
      r0 = res_n;
      hit(v);
      flag_chk(1'b1);
      p = cmp_pin(codes[i], p);
      chk(16'(pin_out[0]), 16'(codes[i] >= 4'hA ? 1'b0 : p));
      chk(16'(trig_n - t0), 16'(codes[i] == 4'hB));
      chk(16'(res_n - r0), 16'(codes[i] == 4'hB));
    end
    wr_reg(enhanced_capture_unit_pkg::ADDR_PORT_DATA, 8'h01);
    wr_reg(enhanced_capture_unit_pkg::ADDR_CONTROL, 8'h00);
    wr_reg(enhanced_capture_unit_pkg::ADDR_CONTROL, 8'h02);
    repeat (3) @(posedge mclk);
    chk(16'(pin_out[0]), 16'h0000);
    $display("test compare done");
    wr_reg(enhanced_capture_unit_pkg::ADDR_PORT_DIR, 8'h00);
    for (int m = 12; m < 16; m++) begin
      for (int b = 0; b < 4; b++) begin
        v = xorshift();
        wr_reg(enhanced_capture_unit_pkg::ADDR_CONTROL, {2'(b), v[5:4], 4'(m)});
        repeat (12) @(posedge mclk);
        if (b == 0) chk(16'(pin_oe[3:1]), 16'h0007);
        if (b == 1) chk(16'(pin_out[0]), 16'(!m[1]));
        if (b == 2) chk(16'(pin_oe[3:2]), 16'h0003);
        if (b == 3) chk(16'(pin_out[2]), 16'(!m[1]));
      end
    end
    $display("test bridge done");
    end_sim();
  end
endmodule : enhanced_capture_mode_control_tb
`default_nettype wire
